// file: sim/tb_top.sv
// self-checking bench for the vector map and stack ram block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, variant, busy, rvalid, vvalid, pvalid, direct, run;
    logic [26:0] pend;
    logic [6:0]  req;
    logic [15:0] pc, addr, sp, vec;
    logic [7:0]  acc, idx, ccr, wdata, rdata, pull_data;
    logic [4:0]  vslot;
    logic [31:0] seed;
    logic [7:0]  vt [52];
    logic [15:0] ram_edge [8] = '{16'h0050, 16'h044f, 16'h0a00, 16'h0dff, 16'h004f, 16'h0450, 16'h09ff, 16'h0e00};
    logic [23:0] q_rd [$];
    logic [23:0] q_vec [$];
    logic [23:0] q_pull [$];
    int          n_errors, n_tests;

    vms_top uut (.CLK_I(clk), .RST_I(rst), .VARIANT_I(variant), .SRC_PEND_I(pend), .INT_REQ_I(req[2]),
        .CALL_I(req[3]), .PUSH_I(req[4]), .PULL_I(req[5]), .RSP_I(req[6]), .PC_I(pc), .ACC_I(acc), .IDX_I(idx),
        .CCR_I(ccr), .PUSH_DATA_I(wdata), .BUS_ADDR_I(addr), .BUS_DIRECT_I(direct), .BUS_WDATA_I(wdata),
        .BUS_WR_I(req[0]), .BUS_RD_I(req[1]), .BUS_RDATA_O(rdata), .BUS_RVALID_O(rvalid), .BUSY_O(busy),
        .SP_O(sp), .VEC_O(vec), .VEC_VALID_O(vvalid), .VEC_SLOT_O(vslot), .PULL_DATA_O(pull_data),
        .PULL_VALID_O(pvalid));
    vms_cpu_model u_cpu (.clk_i(clk), .busy_i(busy), .req_o(req), .addr_o(addr), .data_o(wdata), .direct_o(direct));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_sp(input string n, input logic [15:0] e);
        chk(n, {8'h0, e}, {8'h0, sp});
    endtask

    task automatic chk_rd(input logic [23:0] e);
        chk("read data", e, {16'h0, rdata});
    endtask

    task automatic chk_vec(input logic [23:0] e);
        chk("vector", e, {3'h0, vslot, vec});
    endtask

    task automatic chk_pull(input logic [23:0] e);
        chk("pull data", e, {16'h0, pull_data});
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_idle();
        while (busy)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
        q_rd.push_back({16'h0, e});
        u_cpu.op(1, a, 8'h00, 1'b0);
    endtask

    task automatic irq(input logic [26:0] p, input int s);
        pend = p;
        q_vec.push_back({3'h0, 5'(s), vt[2 * s], vt[2 * s + 1]});
        u_cpu.op(2, 16'h0000, 8'h00, 1'b0);
        wait_idle();
    endtask

    always @(negedge clk)
    begin
        if (run && rvalid)
            chk_rd(q_rd.size() > 0 ? q_rd.pop_front() : 24'hffffff);
        if (run && vvalid)
            chk_vec(q_vec.size() > 0 ? q_vec.pop_front() : 24'hffffff);
        if (run && pvalid)
            chk_pull(q_pull.size() > 0 ? q_pull.pop_front() : 24'hffffff);
    end

    initial
    begin
        #3000000;
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        complete_run();
    end

    initial
    begin
        {seed, rst, variant, pend, pc, acc, idx, ccr, run} = {32'h60c7474d, 1'b1, 1'b0, 27'h0, 40'h0, 1'b0};
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk_sp("sp after reset", 16'h00ff);
        wait_idle();
        chk("reset slot", 24'h000019, {19'h0, vslot});
        // let the unwritten reset vector pulse pass before the monitor starts
        @(posedge clk);
        #1;
        run = 1'b1;
        for (int i = 0; i < 52; i++)
        begin
            vt[i] = 8'(rnd());
            u_cpu.op(0, 16'hffcc + 16'(i), vt[i], 1'b0);
        end
        rd_exp(16'hffec, vt[32]);
        rd_exp(16'hffed, vt[33]);
        for (int i = 0; i < 8; i++)
            u_cpu.op(0, ram_edge[i], 8'ha0 + 8'(i), 1'b0);
        for (int i = 0; i < 8; i++)
            rd_exp(ram_edge[i], i < 4 ? 8'ha0 + 8'(i) : 8'h00);
        q_rd.push_back(24'h0000a0);
        u_cpu.op(1, 16'h5a50, 8'h00, 1'b1);
        for (int v = 0; v < 2; v++)
        begin
            variant = v[0];
            repeat (3) @(posedge clk);
            #1;
            irq(27'h0000010, v ? 10 : 4);
            irq(27'h0010010, v ? 15 : 16);
        end
        irq(27'h2010011, 25);
        // stack kept inside ram from here on
        u_cpu.op(6, 16'h0000, 8'h00, 1'b0);
        u_cpu.op(0, 16'h00fa, 8'h5c, 1'b0);
        {pc, acc, idx, ccr} = {16'(rnd()), 8'(rnd()), 8'(rnd()), 8'(rnd())};
        irq(27'h0010000, 15);
        chk_sp("sp after entry", 16'h00fa);
        rd_exp(16'h00ff, pc[7:0]);
        rd_exp(16'h00fe, pc[15:8]);
        rd_exp(16'h00fd, idx);
        rd_exp(16'h00fc, acc);
        rd_exp(16'h00fb, ccr);
        rd_exp(16'h00fa, 8'h5c);
        pc = 16'(rnd());
        u_cpu.op(3, 16'h0000, 8'h00, 1'b0);
        wait_idle();
        chk_sp("sp after call", 16'h00f8);
        rd_exp(16'h00fa, pc[7:0]);
        rd_exp(16'h00f9, pc[15:8]);
        acc = 8'(rnd());
        u_cpu.op(4, 16'h0000, acc, 1'b0);
        q_pull.push_back({16'h0, acc});
        q_pull.push_back({16'h0, pc[15:8]});
        q_pull.push_back({16'h0, pc[7:0]});
        repeat (3) u_cpu.op(5, 16'h0000, 8'h00, 1'b0);
        wait_idle();
        chk_sp("sp after pulls", 16'h00fa);
        // pull across the page boundary: the carry must reach the upper byte
        u_cpu.op(6, 16'h0000, 8'h00, 1'b0);
        u_cpu.op(0, 16'h0100, 8'h7e, 1'b0);
        q_pull.push_back(24'h00007e);
        u_cpu.op(5, 16'h0000, 8'h00, 1'b0);
        wait_idle();
        chk_sp("sp across page", 16'h0100);
        u_cpu.op(4, 16'h0000, 8'h33, 1'b0);
        q_vec.push_back({3'h0, 5'h19, vt[50], vt[51]});
        rst = 1'b1;
        @(posedge clk);
        #1;
        chk_sp("sp in reset", 16'h00ff);
        rst = 1'b0;
        wait_idle();
        repeat (4) @(posedge clk);
        chk("open notes", 24'h0, 24'(q_rd.size() + q_vec.size() + q_pull.size()));
        complete_run();
    end
endmodule

// file: sim/vms_checker.sv
// concurrent checks on the stack engine, vector fetch and bus answer timing
module vms_checker (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [26:0] SRC_PEND_I,
    input wire logic        INT_REQ_I,
    input wire logic        CALL_I,
    input wire logic        PUSH_I,
    input wire logic        PULL_I,
    input wire logic        RSP_I,
    input wire logic        BUS_WR_I,
    input wire logic        BUS_RD_I,
    input wire logic        BUS_RVALID_O,
    input wire logic        BUSY_O,
    input wire logic [15:0] SP_O,
    input wire logic        VEC_VALID_O,
    input wire logic [4:0]  VEC_SLOT_O,
    input wire logic        PULL_VALID_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    logic no_low;
    logic idle_q;
    assign no_low = !CALL_I && !PUSH_I && !PULL_I;
    assign idle_q = !BUSY_O && !INT_REQ_I && no_low;
    a_read_answer: assert property (idle_q && !RSP_I && BUS_RD_I && !BUS_WR_I |-> ##2 BUS_RVALID_O)
        else $error("read answer missing two cycles after request");
    a_read_cause: assert property (BUS_RVALID_O |-> $past(BUS_RD_I, 2))
        else $error("read answer without a read request");
    a_rsp_restore: assert property (idle_q && RSP_I |=> SP_O == 16'h00ff)
        else $error("stack pointer not restored to 00ff");
    a_push_down: assert property (!BUSY_O && !INT_REQ_I && !CALL_I && PUSH_I
        |-> ##2 SP_O == $past(SP_O, 2) - 16'h0001)
        else $error("push did not lower the stack pointer by one");
    a_pull_up: assert property (!BUSY_O && !INT_REQ_I && !CALL_I && !PUSH_I && PULL_I
        |=> SP_O == $past(SP_O) + 16'h0001 ##1 PULL_VALID_O)
        else $error("pull did not raise the stack pointer or answer");
    a_call_two: assert property (!BUSY_O && !INT_REQ_I && CALL_I |-> ##3 SP_O == $past(SP_O, 3) - 16'h0002)
        else $error("call did not stack two bytes");
    a_int_stack: assert property (!BUSY_O && INT_REQ_I && !SRC_PEND_I[25] && no_low ##1 BUSY_O
        |-> ##8 VEC_VALID_O && SP_O == $past(SP_O, 9) - 16'h0005)
        else $error("interrupt entry did not stack five bytes before the vector");
    a_reset_first: assert property (!BUSY_O && INT_REQ_I && SRC_PEND_I[25]
        |-> ##4 VEC_VALID_O && VEC_SLOT_O == 5'h19 && SP_O == $past(SP_O, 4))
        else $error("pending reset source did not win without stacking");
    a_vec_pulse: assert property (VEC_VALID_O |-> !BUSY_O ##1 !VEC_VALID_O)
        else $error("vector valid not a single pulse at idle");
    a_sp_hold: assert property (idle_q && !RSP_I |=> $stable(SP_O))
        else $error("stack pointer moved without a stack request");
    cover property (VEC_VALID_O && VEC_SLOT_O == 5'h19);
    cover property (PULL_VALID_O);
    cover property (CALL_I && !BUSY_O);
endmodule

bind vms_top vms_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .SRC_PEND_I(SRC_PEND_I), .INT_REQ_I(INT_REQ_I),
    .CALL_I(CALL_I), .PUSH_I(PUSH_I), .PULL_I(PULL_I), .RSP_I(RSP_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
    .BUS_RVALID_O(BUS_RVALID_O), .BUSY_O(BUSY_O), .SP_O(SP_O), .VEC_VALID_O(VEC_VALID_O),
    .VEC_SLOT_O(VEC_SLOT_O), .PULL_VALID_O(PULL_VALID_O));

// file: sim/vms_cpu_model.sv
// behavioural cpu core issuing bus cycles and stack requests
module vms_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        busy_i,
    output logic      [6:0]  req_o,
    output logic      [15:0] addr_o,
    output logic      [7:0]  data_o,
    output logic             direct_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        req_o = '0;
        addr_o = '0;
        data_o = '0;
        direct_o = 1'b0;
    end
    // kind: 0 write, 1 read, 2 interrupt, 3 call, 4 push, 5 pull, 6 stack reset
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d, input logic dir);
        @(posedge clk_i);
        #1;
        while (busy_i)
        begin
            @(posedge clk_i);
            #1;
        end
        addr_o = a;
        data_o = d;
        direct_o = dir;
        req_o = 7'h01 << k;
        @(posedge clk_i);
        #1;
        req_o = '0;
        // released address, data and direct lines show the inverse of their last value; requests drop to zero
        addr_o = ~a;
        data_o = ~d;
        direct_o = ~dir;
    endtask
endmodule

// file: verilog/vms_mem.sv
// byte memory holding the ram windows and the vector table, registered read
module vms_mem (
    input  wire logic clk_i,
    vms_mem_if.mem    m
);
    logic [7:0] mem_r [vms_pkg::MEM_DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (m.we)
        begin
            mem_r[m.addr] <= m.wdata;
        end
        if (int'(m.addr) < vms_pkg::MEM_DEPTH)
        begin
            m.rdata <= mem_r[m.addr];
        end
        else
        begin
            m.rdata <= 8'h00;
        end
    end
endmodule

// file: verilog/vms_mem_if.sv
// carrier between the control logic and its byte memory
interface vms_mem_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// file: verilog/vms_pkg.sv
// constants, address map and types for the vector map and stack ram block
package vms_pkg;
    localparam logic [15:0] VEC_BASE  = 16'hffcc;
    localparam logic [15:0] VEC_TOP   = 16'hffff;
    localparam logic [15:0] RAM1_LO   = 16'h0050;
    localparam logic [15:0] RAM1_HI   = 16'h044f;
    localparam logic [15:0] RAM2_LO   = 16'h0a00;
    localparam logic [15:0] RAM2_HI   = 16'h0dff;
    localparam logic [15:0] SP_RESET  = 16'h00ff;
    localparam logic [7:0]  PAGE0_HI  = 8'h00;
    localparam int          RAM_BYTES = 2048;
    localparam int          PAGE0_RAM_BYTES = 176;
    localparam int          VEC_BYTES = 52;
    localparam int          MEM_DEPTH = RAM_BYTES + VEC_BYTES;
    localparam int          AW        = 12;
    localparam logic [11:0] RAM2_IDX  = 12'h400;
    localparam logic [11:0] VEC_IDX   = 12'h800;
    localparam logic [2:0]  INT_STACK_BYTES  = 3'h5;
    localparam logic [2:0]  CALL_STACK_BYTES = 3'h2;
    localparam logic [2:0]  ONE_BYTE  = 3'h1;
    localparam int          NSLOT     = 26;
    localparam int          NSRC      = 27;
    localparam logic [4:0]  RESET_SLOT = 5'h19;

    // source index -> {valid, slot}; slot 0 sits at the lowest vector address
    localparam logic [5:0] AZ_SLOT [NSRC] = '{
        6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29,
        6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33,
        6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h00};
    localparam logic [5:0] AS_SLOT [NSRC] = '{
        6'h30, 6'h31, 6'h29, 6'h23, 6'h2a, 6'h2b, 6'h2c, 6'h00, 6'h00, 6'h00,
        6'h00, 6'h2d, 6'h2e, 6'h00, 6'h00, 6'h00, 6'h2f, 6'h32, 6'h33, 6'h34,
        6'h35, 6'h27, 6'h36, 6'h37, 6'h38, 6'h39, 6'h28};

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_PUSH = 6'b000010,
        S_VHI  = 6'b000100,
        S_VLO  = 6'b001000,
        S_VEND = 6'b010000,
        S_PULL = 6'b100000
    } vms_state_t;

    typedef struct packed {
        vms_state_t  st;
        logic        v_meta;
        logic        v_sync;
        logic [15:0] sp;
        logic [39:0] stk;
        logic [2:0]  cnt;
        logic        go_vec;
        logic [4:0]  slot;
        logic [7:0]  vec_hi;
        logic        bus_pend;
        logic        rd_hit;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        busy;
        logic [15:0] vec;
        logic        vec_valid;
        logic [4:0]  vec_slot;
        logic [7:0]  pull_data;
        logic        pull_valid;
    } vms_regs_t;

    // cpu address -> {hit, memory index}
    function automatic logic [AW:0] map_addr(input logic [15:0] a);
        logic [AW:0] r;
        r = '0;
        if (a >= RAM1_LO && a <= RAM1_HI)
            r = {1'b1, 12'(a - RAM1_LO)};
        else if (a >= RAM2_LO && a <= RAM2_HI)
            r = {1'b1, 12'(RAM2_IDX + 12'(a - RAM2_LO))};
        else if (a >= VEC_BASE && a <= VEC_TOP)
            r = {1'b1, 12'(VEC_IDX + 12'(a - VEC_BASE))};
        return r;
    endfunction
endpackage

// file: verilog/vms_top.sv
// vector table decode, priority fetch, ram windows and stack engine
module vms_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        VARIANT_I,
    input  wire logic [26:0] SRC_PEND_I,
    input  wire logic        INT_REQ_I,
    input  wire logic        CALL_I,
    input  wire logic        PUSH_I,
    input  wire logic        PULL_I,
    input  wire logic        RSP_I,
    input  wire logic [15:0] PC_I,
    input  wire logic [7:0]  ACC_I,
    input  wire logic [7:0]  IDX_I,
    input  wire logic [7:0]  CCR_I,
    input  wire logic [7:0]  PUSH_DATA_I,
    input  wire logic [15:0] BUS_ADDR_I,
    input  wire logic        BUS_DIRECT_I,
    input  wire logic [7:0]  BUS_WDATA_I,
    input  wire logic        BUS_WR_I,
    input  wire logic        BUS_RD_I,
    output logic      [7:0]  BUS_RDATA_O,
    output logic             BUS_RVALID_O,
    output logic             BUSY_O,
    output logic      [15:0] SP_O,
    output logic      [15:0] VEC_O,
    output logic             VEC_VALID_O,
    output logic      [4:0]  VEC_SLOT_O,
    output logic      [7:0]  PULL_DATA_O,
    output logic             PULL_VALID_O
);
    localparam vms_pkg::vms_regs_t REGS_RST = '{
        st:         vms_pkg::S_VHI,
        v_meta:     1'b0,
        v_sync:     1'b0,
        sp:         vms_pkg::SP_RESET,
        stk:        40'h0,
        cnt:        3'h0,
        go_vec:     1'b0,
        slot:       vms_pkg::RESET_SLOT,
        vec_hi:     8'h00,
        bus_pend:   1'b0,
        rd_hit:     1'b0,
        rdata:      8'h00,
        rvalid:     1'b0,
        busy:       1'b1,
        vec:        16'h0000,
        vec_valid:  1'b0,
        vec_slot:   5'h00,
        pull_data:  8'h00,
        pull_valid: 1'b0
    };

    vms_pkg::vms_regs_t r;
    vms_pkg::vms_regs_t n;
    vms_mem_if          m ();

    vms_mem u_mem (
        .clk_i (CLK_I),
        .m     (m.mem)
    );

    // pending sources folded onto vector slots for the selected variant
    function automatic logic [vms_pkg::NSLOT-1:0] slot_pend(input logic [26:0] src, input logic v);
        logic [vms_pkg::NSLOT-1:0] p;
        logic [5:0]                mp;
        p = '0;
        for (int i = 0; i < vms_pkg::NSRC; i++)
        begin
            mp = v ? vms_pkg::AS_SLOT[i] : vms_pkg::AZ_SLOT[i];
            if (mp[5] && src[i])
                p[mp[4:0]] = 1'b1;
        end
        return p;
    endfunction

    // highest pending slot; later (higher address) slots override earlier ones
    function automatic logic [4:0] top_slot(input logic [vms_pkg::NSLOT-1:0] p);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < vms_pkg::NSLOT; i++)
        begin
            if (p[i])
                s = 5'(i);
        end
        return s;
    endfunction

    // memory index of one byte of a vector pair
    function automatic logic [11:0] vec_idx(input logic [4:0] s, input logic lo);
        return 12'(vms_pkg::VEC_IDX + 12'({s, lo}));
    endfunction

    always_comb
    begin
        logic [vms_pkg::AW:0]      hit;
        logic [vms_pkg::NSLOT-1:0] pend;
        logic [15:0]               badr;
        hit  = '0;
        pend = slot_pend(SRC_PEND_I, r.v_sync);
        badr = BUS_DIRECT_I ? {vms_pkg::PAGE0_HI, BUS_ADDR_I[7:0]} : BUS_ADDR_I;
        n            = r;
        n.v_meta     = VARIANT_I;
        n.v_sync     = r.v_meta;
        n.rvalid     = 1'b0;
        n.vec_valid  = 1'b0;
        n.pull_valid = 1'b0;
        n.bus_pend   = 1'b0;
        m.addr       = 12'h000;
        m.wdata      = 8'h00;
        m.we         = 1'b0;
        if (r.bus_pend)
        begin
            n.rdata  = r.rd_hit ? m.rdata : 8'h00;
            n.rvalid = 1'b1;
        end
        unique case (r.st)
            vms_pkg::S_IDLE:
            begin
                if (INT_REQ_I && (pend != '0))
                begin
                    n.slot   = top_slot(pend);
                    n.stk    = {CCR_I, ACC_I, IDX_I, PC_I[15:8], PC_I[7:0]};
                    n.cnt    = vms_pkg::INT_STACK_BYTES;
                    n.go_vec = 1'b1;
                    n.st     = (top_slot(pend) == vms_pkg::RESET_SLOT) ? vms_pkg::S_VHI : vms_pkg::S_PUSH;
                end
                else if (CALL_I)
                begin
                    n.stk    = {24'h000000, PC_I[15:8], PC_I[7:0]};
                    n.cnt    = vms_pkg::CALL_STACK_BYTES;
                    n.go_vec = 1'b0;
                    n.st     = vms_pkg::S_PUSH;
                end
                else if (PUSH_I)
                begin
                    n.stk    = {32'h00000000, PUSH_DATA_I};
                    n.cnt    = vms_pkg::ONE_BYTE;
                    n.go_vec = 1'b0;
                    n.st     = vms_pkg::S_PUSH;
                end
                else if (PULL_I)
                begin
                    n.sp     = r.sp + 16'h0001;
                    hit      = vms_pkg::map_addr(r.sp + 16'h0001);
                    m.addr   = hit[11:0];
                    n.rd_hit = hit[12];
                    n.st     = vms_pkg::S_PULL;
                end
                else if (RSP_I)
                begin
                    n.sp = vms_pkg::SP_RESET;
                end
                else if (BUS_WR_I || BUS_RD_I)
                begin
                    hit        = vms_pkg::map_addr(badr);
                    m.addr     = hit[11:0];
                    m.wdata    = BUS_WDATA_I;
                    m.we       = BUS_WR_I && hit[12];
                    n.bus_pend = BUS_RD_I && !BUS_WR_I;
                    n.rd_hit   = hit[12];
                end
            end
            vms_pkg::S_PUSH:
            begin
                hit     = vms_pkg::map_addr(r.sp);
                m.addr  = hit[11:0];
                m.wdata = r.stk[7:0];
                m.we    = hit[12];
                n.stk   = {8'h00, r.stk[39:8]};
                n.sp    = r.sp - 16'h0001;
                n.cnt   = r.cnt - 3'h1;
                if (r.cnt == vms_pkg::ONE_BYTE)
                    n.st = r.go_vec ? vms_pkg::S_VHI : vms_pkg::S_IDLE;
            end
            vms_pkg::S_VHI:
            begin
                m.addr = vec_idx(r.slot, 1'b0);
                n.st   = vms_pkg::S_VLO;
            end
            vms_pkg::S_VLO:
            begin
                m.addr   = vec_idx(r.slot, 1'b1);
                n.vec_hi = m.rdata;
                n.st     = vms_pkg::S_VEND;
            end
            vms_pkg::S_VEND:
            begin
                n.vec       = {r.vec_hi, m.rdata};
                n.vec_valid = 1'b1;
                n.vec_slot  = r.slot;
                n.st        = vms_pkg::S_IDLE;
            end
            vms_pkg::S_PULL:
            begin
                n.pull_data  = r.rd_hit ? m.rdata : 8'h00;
                n.pull_valid = 1'b1;
                n.st         = vms_pkg::S_IDLE;
            end
        endcase
        n.busy = (n.st != vms_pkg::S_IDLE);
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            r <= REGS_RST;
        else
            r <= n;
    end

    assign BUS_RDATA_O  = r.rdata;
    assign BUS_RVALID_O = r.rvalid;
    assign BUSY_O       = r.busy;
    assign SP_O         = r.sp;
    assign VEC_O        = r.vec;
    assign VEC_VALID_O  = r.vec_valid;
    assign VEC_SLOT_O   = r.vec_slot;
    assign PULL_DATA_O  = r.pull_data;
    assign PULL_VALID_O = r.pull_valid;
endmodule
